// ===== rtl/dsp_exec_params.svh
// Constants for the add, logic and branch execution unit.
// Assumes inclusion by bare name from design files only.
`ifndef DSP_EXEC_PARAMS_SVH
`define DSP_EXEC_PARAMS_SVH
`define DW          16
`define AW          32
`define PCW         12
`define IDXW        9
`define ACC_RST     32'h0000_0000
`define PC_RST      12'h000
`define PC_STEP1    12'h001
`define PC_STEP2    12'h002
`define IDX_STEP    9'h001
`define SYNC_STAGES 3
`endif

// ===== rtl/dsp_exec_pkg.sv
// Types shared by the execution unit files.
// Assumes the params header is compiled alongside.
package dsp_exec_pkg;
    typedef enum logic [3:0] {
        op_none,
        op_add_unsigned_word,
        op_and_low,
        op_accumulate_product,
        op_branch,
        op_loop_branch_index_nonzero,
        op_branch_sum_nonnegative,
        op_branch_sum_positive,
        op_branch_sum_nonpositive,
        op_branch_sum_negative,
        op_branch_on_pin_low
    } exec_op_e;
    typedef enum logic [1:0] {
        st_idle,
        st_fetch2
    } exec_state_e;
endpackage

// ===== rtl/pin_sync.sv
// Three-stage synchroniser for one asynchronous pin.
// Assumes a single clock; output changes once stages two and three agree.
`timescale 1ns/1ps
`include "dsp_exec_params.svh"
module pin_sync (
    // Clock and control
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic clk_en_in,
    input  wire logic reset_level_in,
    // Pin
    input  wire logic pin_in,
    output logic      level_out
);
    logic [`SYNC_STAGES-1:0] stage;
    wire                     agree = (stage[`SYNC_STAGES-2] ==
                                      stage[`SYNC_STAGES-1]);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            stage     <= {`SYNC_STAGES{reset_level_in}};
            level_out <= reset_level_in;
        end else if (clk_en_in) begin
            stage <= {stage[`SYNC_STAGES-2:0], pin_in};
            if (agree) begin
                level_out <= stage[`SYNC_STAGES-1];
            end
        end
    end
endmodule

// ===== rtl/dsp_add_logic_branch_exec.sv
// Execution unit for unsigned add, low mask, product accumulate and branches.
// Assumes an outside decoder presents one op per cycle when op_ready_out
// is high, with the data word already read; branch second words arrive on
// prog_word_in with prog_valid_in.
`timescale 1ns/1ps
`include "dsp_exec_params.svh"
// Functional notes
// - Unsigned add: zero-extended word, one cycle
// - Mask: AND low half, clear upper bits
// - Add product register into accumulator, one cycle
// - Branch loads counter from second word
// - Loop branch: nonzero index jumps and decrements
// - Zero index: skip two, still decrement
// - Index decrement wraps modulo 512
// - Jump when accumulator nonnegative, else skip
// - Jump when accumulator strictly positive, else skip
// - Jump when test pin low, else skip
// - Jump when accumulator nonpositive, else skip
// - Jump when accumulator negative, else skip
module dsp_add_logic_branch_exec (
    // Clock, reset, enable
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  clk_en_in,
    // Operation request
    input  wire logic                  op_valid_in,
    input  wire dsp_exec_pkg::exec_op_e op_in,
    input  wire logic [`DW-1:0]        data_word_in,
    input  wire logic [`AW-1:0]        product_in,
    input  wire logic                  index_select_in,
    // Program memory second word
    input  wire logic                  prog_valid_in,
    input  wire logic [`DW-1:0]        prog_word_in,
    // External pin, active low
    input  wire logic                  external_test_input_n_in,
    // State out
    output logic [`AW-1:0]             acc_out,
    output logic [`PCW-1:0]            pc_out,
    output logic [`IDXW-1:0]           index0_out,
    output logic [`IDXW-1:0]           index1_out,
    output logic                       op_ready_out,
    output logic                       prog_fetch_out
);
    // ****************************************
    // Pin synchroniser
    // ****************************************
    logic pin_level;

    pin_sync u_pin_sync (
        .core_clk_in    (core_clk_in),
        .rst_in         (rst_in),
        .clk_en_in      (clk_en_in),
        .reset_level_in (1'b1),
        .pin_in         (external_test_input_n_in),
        .level_out      (pin_level)
    );

    // ****************************************
    // State
    // ****************************************
    dsp_exec_pkg::exec_state_e state;
    dsp_exec_pkg::exec_op_e    held_op;
    logic [`IDXW-1:0]          index [2];
    logic                      held_sel;

    // ****************************************
    // Decode
    // ****************************************
    wire take = op_valid_in && op_ready_out;
    wire two_word = take &&
        (op_in != dsp_exec_pkg::op_none) &&
        (op_in != dsp_exec_pkg::op_add_unsigned_word) &&
        (op_in != dsp_exec_pkg::op_and_low) &&
        (op_in != dsp_exec_pkg::op_accumulate_product);

    // Zero extension keeps the upper half free of sign bits
    wire [`AW-1:0] ext_word   = {{(`AW-`DW){1'b0}}, data_word_in};
    wire [`AW-1:0] sum_word   = acc_out + ext_word;
    wire [`AW-1:0] mask_word  = {{(`AW-`DW){1'b0}},
                                 acc_out[`DW-1:0] & data_word_in};
    wire [`AW-1:0] sum_prod   = acc_out + product_in;

    wire acc_neg  = acc_out[`AW-1];
    wire acc_zero = (acc_out == {`AW{1'b0}});

    wire [`IDXW-1:0] cur_idx  = index[held_sel];
    wire             idx_nz   = (cur_idx != {`IDXW{1'b0}});
    wire [`IDXW-1:0] idx_dec  = cur_idx - `IDX_STEP;

    logic jump;
    always_comb begin
        case (held_op)
            dsp_exec_pkg::op_branch:
                jump = 1'b1;
            dsp_exec_pkg::op_loop_branch_index_nonzero:
                jump = idx_nz;
            dsp_exec_pkg::op_branch_sum_nonnegative:
                jump = !acc_neg;
            dsp_exec_pkg::op_branch_sum_positive:
                jump = !acc_neg && !acc_zero;
            dsp_exec_pkg::op_branch_sum_nonpositive:
                jump = acc_neg || acc_zero;
            dsp_exec_pkg::op_branch_sum_negative:
                jump = acc_neg;
            dsp_exec_pkg::op_branch_on_pin_low:
                jump = !pin_level;
            default:                                    jump = 1'b0;
        endcase
    end

    wire finish = (state == dsp_exec_pkg::st_fetch2) && prog_valid_in;
    // Upper four bits of the second word are dropped
    wire [`PCW-1:0] target = prog_word_in[`PCW-1:0];
    // The counter already stepped once past the first word
    wire [`PCW-1:0] skip   = pc_out + `PC_STEP1;

    logic [`AW-1:0] next_acc;
    always_comb begin
        next_acc = acc_out;
        if (take) begin
            case (op_in)
                dsp_exec_pkg::op_add_unsigned_word:  next_acc = sum_word;
                dsp_exec_pkg::op_and_low:            next_acc = mask_word;
                dsp_exec_pkg::op_accumulate_product: next_acc = sum_prod;
                default:                             next_acc = acc_out;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state          <= dsp_exec_pkg::st_idle;
            held_op        <= dsp_exec_pkg::op_none;
            held_sel       <= 1'b0;
            acc_out        <= `ACC_RST;
            pc_out         <= `PC_RST;
            index[0]       <= {`IDXW{1'b0}};
            index[1]       <= {`IDXW{1'b0}};
            index0_out     <= {`IDXW{1'b0}};
            index1_out     <= {`IDXW{1'b0}};
            op_ready_out   <= 1'b1;
            prog_fetch_out <= 1'b0;
        end else if (clk_en_in) begin
            acc_out <= next_acc;
            case (state)
                dsp_exec_pkg::st_idle: begin
                    if (take) begin
                        pc_out <= pc_out + `PC_STEP1;
                    end
                    if (two_word) begin
                        state          <= dsp_exec_pkg::st_fetch2;
                        held_op        <= op_in;
                        held_sel       <= index_select_in;
                        op_ready_out   <= 1'b0;
                        prog_fetch_out <= 1'b1;
                    end
                end
                dsp_exec_pkg::st_fetch2: begin
                    if (finish) begin
                        pc_out         <= jump ? target : skip;
                        state          <= dsp_exec_pkg::st_idle;
                        op_ready_out   <= 1'b1;
                        prog_fetch_out <= 1'b0;
                        if (held_op ==
                            dsp_exec_pkg::op_loop_branch_index_nonzero) begin
                            index[held_sel] <= idx_dec;
                            if (held_sel) begin
                                index1_out <= idx_dec;
                            end else begin
                                index0_out <= idx_dec;
                            end
                        end
                    end
                end
                default: state <= dsp_exec_pkg::st_idle;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_add_unsigned;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && take && op_in == dsp_exec_pkg::op_add_unsigned_word)
        |=> acc_out == $past(acc_out) +
            {{(`AW-`DW){1'b0}}, $past(data_word_in)};
    endproperty
    a_add_unsigned: assert property (p_add_unsigned)
        else $error("unsigned add result wrong");

    property p_mask;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && take && op_in == dsp_exec_pkg::op_and_low)
        |=> acc_out[`AW-1:`DW] == {(`AW-`DW){1'b0}} &&
            acc_out[`DW-1:0] ==
            ($past(acc_out[`DW-1:0]) & $past(data_word_in));
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask result wrong");

    property p_prod;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && take && op_in == dsp_exec_pkg::op_accumulate_product)
        |=> acc_out == $past(acc_out) + $past(product_in);
    endproperty
    a_prod: assert property (p_prod)
        else $error("product accumulate wrong");

    property p_branch;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && finish && held_op == dsp_exec_pkg::op_branch)
        |=> pc_out == $past(prog_word_in[`PCW-1:0]);
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch target wrong");

    property p_loop_dec;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && finish &&
         held_op == dsp_exec_pkg::op_loop_branch_index_nonzero && !held_sel)
        |=> index0_out == $past(index[0]) - `IDX_STEP;
    endproperty
    a_loop_dec: assert property (p_loop_dec)
        else $error("index decrement wrong");

    property p_loop_zero;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && finish &&
         held_op == dsp_exec_pkg::op_loop_branch_index_nonzero && !idx_nz)
        |=> pc_out == $past(pc_out) + `PC_STEP1;
    endproperty
    a_loop_zero: assert property (p_loop_zero)
        else $error("loop skip wrong");

    property p_nonneg;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && finish &&
         held_op == dsp_exec_pkg::op_branch_sum_nonnegative && !acc_neg)
        |=> pc_out == $past(prog_word_in[`PCW-1:0]);
    endproperty
    a_nonneg: assert property (p_nonneg)
        else $error("nonnegative branch wrong");

    property p_pos;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && finish &&
         held_op == dsp_exec_pkg::op_branch_sum_positive && acc_zero)
        |=> pc_out == $past(pc_out) + `PC_STEP1;
    endproperty
    a_pos: assert property (p_pos)
        else $error("positive branch taken on zero");

    // First word of a branch steps the counter once and blocks new ops
    sequence s_two_word;
        clk_en_in && two_word ##1 prog_fetch_out && !op_ready_out;
    endsequence
    property p_two_cycle;
        @(posedge core_clk_in) disable iff (rst_in)
        s_two_word |-> pc_out == $past(pc_out) + `PC_STEP1;
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("first branch word step wrong");
endmodule

// ===== verif/prog_source_model.sv
// Far-side model: program memory second word and the test pin.
// Assumes prog_fetch_in is the exec unit's registered fetch flag.
`timescale 1ns/1ps
module prog_source_model (
    // Clock
    input  wire logic        core_clk_in,
    // Bench control
    input  wire logic [1:0]  delay_in,
    input  wire logic [15:0] target_in,
    input  wire logic        pin_low_in,
    // Exec unit side
    input  wire logic        prog_fetch_in,
    output logic             prog_valid_out,
    output logic             test_n_out,
    output logic [15:0]      prog_word_out
);
    // ****************
    // Memory answer
    // ****************
    logic [1:0]  waited = 2'h0;
    logic [15:0] noise  = 16'h5a3c;
    // Word held until taken; churns otherwise so stale reads show
    assign prog_valid_out = prog_fetch_in && (waited >= delay_in);
    assign prog_word_out  = prog_valid_out ? target_in : noise;
    // Pulled low whenever the bench drives pin_low_in high
    assign test_n_out     = !pin_low_in;
    always_ff @(posedge core_clk_in) begin
        noise  <= {noise[14:0], ~noise[15]};
        waited <= !prog_fetch_in ? 2'h0 :
                  (waited == 2'h3 ? waited : waited + 2'h1);
    end
endmodule

// ===== verif/dsp_add_logic_branch_exec_test.sv
// Self-checking bench for the add, logic and branch execution unit.
// Assumes prog_source_model answers every second-word fetch.
`timescale 1ns/1ps
module dsp_add_logic_branch_exec_test;
    // ****************
    // Signals
    // ****************
    logic                   clk;
    logic                   rst;
    logic                   clk_en;
    logic                   op_valid;
    logic                   sel;
    logic                   prog_valid;
    logic                   test_n;
    logic                   ready;
    logic                   fetch;
    logic                   pin_low;
    dsp_exec_pkg::exec_op_e op;
    logic [15:0]            data_word;
    logic [15:0]            prog_word;
    logic [15:0]            target;
    logic [31:0]            product;
    logic [31:0]            acc;
    logic [31:0]            e_acc;
    logic [31:0]            r;
    logic [11:0]            pc;
    logic [11:0]            e_pc;
    logic [8:0]             idx0;
    logic [8:0]             idx1;
    logic [8:0]             e_idx [2];
    logic [1:0]             delay;
    integer                 seed = 32'h6aece5bf;
    int                     failures = 0;
    int                     check_count = 0;

    dsp_add_logic_branch_exec u_dsp_add_logic_branch_exec (
        .core_clk_in(clk), .rst_in(rst), .clk_en_in(clk_en),
        .op_valid_in(op_valid), .op_in(op), .data_word_in(data_word),
        .product_in(product), .index_select_in(sel),
        .prog_valid_in(prog_valid), .prog_word_in(prog_word),
        .external_test_input_n_in(test_n), .acc_out(acc), .pc_out(pc),
        .index0_out(idx0), .index1_out(idx1), .op_ready_out(ready),
        .prog_fetch_out(fetch));
    prog_source_model u_prog_source_model (
        .core_clk_in(clk), .delay_in(delay), .target_in(target),
        .pin_low_in(pin_low), .prog_fetch_in(fetch),
        .prog_valid_out(prog_valid), .test_n_out(test_n),
        .prog_word_out(prog_word));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****************
    // Helpers
    // ****************
    task automatic check(input logic [31:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    function automatic logic taken(dsp_exec_pkg::exec_op_e o,
                                   logic [31:0] a, logic [8:0] ix);
        case (o)
            dsp_exec_pkg::op_branch:                    return 1'b1;
            dsp_exec_pkg::op_loop_branch_index_nonzero: return ix != 9'h0;
            dsp_exec_pkg::op_branch_sum_nonnegative:    return !a[31];
            dsp_exec_pkg::op_branch_sum_positive:   return !a[31] && a != 0;
            dsp_exec_pkg::op_branch_sum_nonpositive: return a[31] || a == 0;
            dsp_exec_pkg::op_branch_sum_negative:       return a[31];
            dsp_exec_pkg::op_branch_on_pin_low:         return pin_low;
            default:                                    return 1'b0;
        endcase
    endfunction
    function automatic logic [31:0] next_acc(dsp_exec_pkg::exec_op_e o,
                                             logic [15:0] d, logic [31:0] p);
        case (o)
            dsp_exec_pkg::op_add_unsigned_word:  return e_acc + {16'h0, d};
            dsp_exec_pkg::op_and_low:  return {16'h0, e_acc[15:0] & d};
            dsp_exec_pkg::op_accumulate_product: return e_acc + p;
            default:                             return e_acc;
        endcase
    endfunction
    task automatic run_op(input dsp_exec_pkg::exec_op_e o,
                          input logic [15:0] d, input logic [31:0] p,
                          input logic s, input logic [15:0] t);
        int   n;
        logic tk;
        logic two;
        tk = taken(o, e_acc, e_idx[s]);
        two = o >= dsp_exec_pkg::op_branch;
        @(posedge clk);
        op_valid <= 1'b1;
        op <= o;
        data_word <= d;
        product <= p;
        sel <= s;
        target <= t;
        @(posedge clk);
        op_valid <= 1'b0;
        e_acc = next_acc(o, d, p);
        if (o == dsp_exec_pkg::op_loop_branch_index_nonzero)
            e_idx[s] = e_idx[s] - 9'h1;
        e_pc = two ? (tk ? t[11:0] : e_pc + 12'h2) : e_pc + 12'h1;
        n = 1;
        #1;
        check(32'(fetch), 32'(two), "fetch");
        while (ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
            #1;
        end
        check(acc, e_acc, "acc");
        check(32'(pc), 32'(e_pc), "pc");
        check(32'(idx0), 32'(e_idx[0]), "index0");
        check(32'(idx1), 32'(e_idx[1]), "index1");
        check(32'(n), two ? 32'(2 + delay) : 32'h1, "cycles");
    endtask
    // Zero, positive and negative sums each meet all four sign tests
    task automatic sweep();
        for (int k = 6; k <= 9; k++)
            run_op(dsp_exec_pkg::exec_op_e'(k), 16'h0, 32'h0, 1'b0,
                   16'ha321);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        rst = 1'b1;
        op_valid = 1'b0;
        clk_en = 1'b1;
        op = dsp_exec_pkg::op_none;
        {data_word, product, sel, delay, target, pin_low} = '0;
        {e_acc, e_pc, e_idx[0], e_idx[1]} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        run_op(dsp_exec_pkg::op_loop_branch_index_nonzero, 16'h0, 32'h0,
               1'b0, 16'hf0a5);
        delay <= 2'h3;
        run_op(dsp_exec_pkg::op_loop_branch_index_nonzero, 16'h0, 32'h0,
               1'b0, 16'h1234);
        run_op(dsp_exec_pkg::op_branch, 16'h0, 32'h0, 1'b1, 16'hf7e1);
        delay <= 2'h0;
        sweep();
        for (int k = 0; k < 2; k++)
            run_op(dsp_exec_pkg::op_add_unsigned_word, 16'hffff, 32'h0,
                   1'b0, 16'h0);
        sweep();
        run_op(dsp_exec_pkg::op_and_low, 16'h0ff0, 32'h0, 1'b0,
               16'h0);
        run_op(dsp_exec_pkg::op_accumulate_product, 16'h0, 32'hffff_f000,
               1'b0, 16'h0);
        sweep();
        for (int k = 0; k < 2; k++) begin
            pin_low <= !k[0];
            repeat (5) @(posedge clk);
            run_op(dsp_exec_pkg::op_branch_on_pin_low, 16'h0, 32'h0, 1'b0,
                   16'h0456);
        end
        // Enable low freezes state even with a request pending
        clk_en <= 1'b0;
        op_valid <= 1'b1;
        op <= dsp_exec_pkg::op_add_unsigned_word;
        data_word <= 16'h0001;
        repeat (3) @(posedge clk);
        #1;
        check(acc, e_acc, "frozen acc");
        check(32'(pc), 32'(e_pc), "frozen pc");
        @(posedge clk);
        op_valid <= 1'b0;
        clk_en <= 1'b1;
        run_op(dsp_exec_pkg::op_none, 16'h0, 32'h0, 1'b0, 16'h0);
        $display("test corner done");
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            delay <= r[5:4];
            if (r[3:0] % 4'hb == 4'ha) begin
                pin_low <= r[6];
                repeat (5) @(posedge clk);
            end
            run_op(dsp_exec_pkg::exec_op_e'(r[3:0] % 4'hb), r[31:16],
                   $random(seed), r[7], {r[11:8], r[27:16]});
        end
        $display("test random done");
        // Reset in mid-run returns every output to its reset value
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        {e_acc, e_pc, e_idx[0], e_idx[1]} = '0;
        #1;
        check(acc, 32'h0, "reset acc");
        check(32'(pc), 32'h0, "reset pc");
        check(32'({idx0, idx1}), 32'h0, "reset index");
        check(32'({ready, fetch}), 32'h2, "reset handshake");
        run_op(dsp_exec_pkg::op_branch, 16'h0, 32'h0, 1'b0, 16'h0abc);
        $display("test reset done");
        summarize();
    end
endmodule
